// ==== core/mil_consts.vh ====
`ifndef MIL_CONSTS_VH
`define MIL_CONSTS_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define MIL_ADDR_INTCTL 8'h00
`define MIL_ADDR_PFLAG 8'h04
`define MIL_ADDR_PEN 8'h08
`define MIL_ADDR_OPTION 8'h0c
`define MIL_ADDR_EVT_STAT 8'h10
`define MIL_ADDR_EVT_MASK 8'h14
`define MIL_ADDR_VECTOR 8'h18

// ----------------------------------------
// interrupt control register fields
// ----------------------------------------
`define MIL_IC_GLOBAL_EN 7
`define MIL_IC_PERIPH_EN 6
`define MIL_IC_TIMER0_EN 5
`define MIL_IC_EXT_EN 4
`define MIL_IC_PORT_EN 3
`define MIL_IC_TIMER0_FLAG 2
`define MIL_IC_EXT_FLAG 1
`define MIL_IC_PORT_FLAG 0

// ----------------------------------------
// option register fields and reset values
// ----------------------------------------
`define MIL_OPT_EDGE 6
`define MIL_INTCTL_RST 8'h00
`define MIL_OPTION_RST 8'hff
`define MIL_PERIPH_RST 6'h00

// ----------------------------------------
// event status bits
// ----------------------------------------
`define MIL_EV_VECTOR 0
`define MIL_EV_WAKE 1
`define MIL_EV_RETURN 2

// ----------------------------------------
// vector and timer0 limits
// ----------------------------------------
`define MIL_VECTOR_ADDR 13'h0004
`define MIL_TIMER0_MAX 8'hff
`define MIL_TIMER0_ZERO 8'h00

`endif

// ==== core/mil_irq_logic.v ====
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "mil_consts.vh"

// Notes on behaviour
// - nine sources: pin, timer0, port change and six peripheral events.
// - each flag sets on its event whatever any enable says.
// - global enable bit 7 passes unmasked requests; clear blocks them all from vectoring, not from wake.
// - global enable plus flag and enable set vectors one instruction boundary later, via pend_r.
// - global enable clears on every reset.
// - taking a request clears global enable, pushes pc, loads vector.
// - return-from-interrupt sets global enable again.
// - peripheral flags and enables live apart; group enable in control.
// - pin, port change and timer0 flags live in the control register.
// - external event to vector takes three or four instruction cycles.
// - pin edge is rising when option bit 6 is set, else falling.
// - valid pin edge sets control bit 1; bit 4 masks it.
// - pin event wakes from sleep only when its enable is set.
// - timer0 rollover from all ones to zero sets bit 2, gated bit 5.
// - change on the upper port nibble sets bit 0, own enable gates.
// - hardware saves only the return pc; software saves the rest.
// - enabled request wakes whatever global enable; no vector if clear.
module mil_irq_logic #(
    parameter PERIPH_N = 6,
    parameter PC_W = 13
) (
    input wire sys_clk,
    input wire sys_rst,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire ext_irq_pin,
    input wire [3:0] upper_nibble_port,
    input wire [7:0] timer0_count,
    input wire [PERIPH_N-1:0] periph_event,
    input wire insn_boundary,
    input wire sleep_active,
    input wire return_from_irq_instr,
    input wire [PC_W-1:0] return_pc,
    output reg pc_load_r,
    output reg [PC_W-1:0] pc_value_r,
    output reg stack_push_r,
    output reg [PC_W-1:0] stack_data_r,
    output reg wake_r,
    output reg irq_out_r
);

// ----------------------------------------
// state
// ----------------------------------------
reg [7:0] intctl_r;
reg [PERIPH_N-1:0] pflag_r;
reg [PERIPH_N-1:0] pen_r;
reg [7:0] option_r;
reg [2:0] evt_stat_r;
reg [2:0] evt_mask_r;
reg pin_q_r;
reg [3:0] port_q_r;
reg [7:0] timer0_q_r;
reg pend_r;

wire wr_en;
wire rd_en;
wire addr_ok;
wire edge_sel;
wire pin_edge;
wire port_chg;
wire timer0_ovf;
wire any_active;
wire take;
wire [7:0] ic_set;
wire [2:0] ev_set;

// ----------------------------------------
// event detection
// ----------------------------------------
assign edge_sel = option_r[`MIL_OPT_EDGE];
// only the previous sample is registered, so the edge shows in the cycle the pin changes
assign pin_edge = edge_sel ? (ext_irq_pin & ~pin_q_r) :
                  (~ext_irq_pin & pin_q_r);
assign port_chg = |(upper_nibble_port ^ port_q_r);
assign timer0_ovf = (timer0_q_r == `MIL_TIMER0_MAX) &&
                    (timer0_count == `MIL_TIMER0_ZERO);

// flags set regardless of any enable
assign ic_set = {5'h00, timer0_ovf, pin_edge, port_chg};

assign any_active =
    (intctl_r[`MIL_IC_TIMER0_FLAG] & intctl_r[`MIL_IC_TIMER0_EN]) |
    (intctl_r[`MIL_IC_EXT_FLAG] & intctl_r[`MIL_IC_EXT_EN]) |
    (intctl_r[`MIL_IC_PORT_FLAG] & intctl_r[`MIL_IC_PORT_EN]) |
    (intctl_r[`MIL_IC_PERIPH_EN] & |(pflag_r & pen_r));

// pend_r adds one instruction boundary, giving three or four cycles
assign take = insn_boundary & pend_r & intctl_r[`MIL_IC_GLOBAL_EN] &
              any_active & ~sleep_active;

assign ev_set = {return_from_irq_instr, sleep_active & any_active, take};

// ----------------------------------------
// apb decode
// ----------------------------------------
assign addr_ok = (paddr == `MIL_ADDR_INTCTL) ||
                 (paddr == `MIL_ADDR_PFLAG) ||
                 (paddr == `MIL_ADDR_PEN) ||
                 (paddr == `MIL_ADDR_OPTION) ||
                 (paddr == `MIL_ADDR_EVT_STAT) ||
                 (paddr == `MIL_ADDR_EVT_MASK) ||
                 (paddr == `MIL_ADDR_VECTOR);
// one wait state: effect lands on the edge where pready is high
assign wr_en = psel & penable & pready & pwrite & addr_ok;
assign rd_en = psel & penable & ~pready & ~pwrite;

always @(posedge sys_clk) begin
    if (sys_rst) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
    end else begin
        pready <= psel & penable & ~pready;
        pslverr <= psel & penable & ~pready & ~addr_ok;
        if (rd_en) begin
            case (paddr)
                `MIL_ADDR_INTCTL: prdata <= {24'h000000, intctl_r};
                `MIL_ADDR_PFLAG: prdata <= {{(32-PERIPH_N){1'b0}}, pflag_r};
                `MIL_ADDR_PEN: prdata <= {{(32-PERIPH_N){1'b0}}, pen_r};
                `MIL_ADDR_OPTION: prdata <= {24'h000000, option_r};
                `MIL_ADDR_EVT_STAT: prdata <= {29'h0, evt_stat_r};
                `MIL_ADDR_EVT_MASK: prdata <= {29'h0, evt_mask_r};
                `MIL_ADDR_VECTOR: prdata <= {{(32-PC_W){1'b0}},
                                             `MIL_VECTOR_ADDR};
                default: prdata <= 32'h0000_0000;
            endcase
        end else begin
            // read data stands only in the cycle that pready stands
            prdata <= 32'h0000_0000;
        end
    end
end

// ----------------------------------------
// register write strobes
// ----------------------------------------
reg [7:0] intctl_nxt;
reg [PERIPH_N-1:0] pflag_nxt;
reg [PERIPH_N-1:0] pen_nxt;
reg [7:0] option_nxt;
reg [2:0] evt_stat_nxt;
reg [2:0] evt_mask_nxt;
reg pend_nxt;
wire intctl_wr;
wire pflag_wr;
wire pen_wr;
wire option_wr;
wire evt_stat_wr;
wire evt_mask_wr;

assign intctl_wr = wr_en && (paddr == `MIL_ADDR_INTCTL);
assign pflag_wr = wr_en && (paddr == `MIL_ADDR_PFLAG);
assign pen_wr = wr_en && (paddr == `MIL_ADDR_PEN);
assign option_wr = wr_en && (paddr == `MIL_ADDR_OPTION);
assign evt_stat_wr = wr_en && (paddr == `MIL_ADDR_EVT_STAT);
assign evt_mask_wr = wr_en && (paddr == `MIL_ADDR_EVT_MASK);

// ----------------------------------------
// interrupt control next value
// ----------------------------------------
always @* begin
    intctl_nxt = intctl_r;
    // hardware sets win over a clearing write
    if (intctl_wr) begin
        intctl_nxt[6:0] = pwdata[6:0] | ic_set[6:0];
    end else begin
        intctl_nxt[6:0] = intctl_r[6:0] | ic_set[6:0];
    end
    // a take outranks a return, a return outranks software
    if (take) begin
        intctl_nxt[`MIL_IC_GLOBAL_EN] = 1'b0;
    end else if (return_from_irq_instr) begin
        intctl_nxt[`MIL_IC_GLOBAL_EN] = 1'b1;
    end else if (intctl_wr) begin
        intctl_nxt[`MIL_IC_GLOBAL_EN] = pwdata[`MIL_IC_GLOBAL_EN];
    end
end

// ----------------------------------------
// peripheral, option and event next values
// ----------------------------------------
always @* begin
    if (pflag_wr) begin
        pflag_nxt = pwdata[PERIPH_N-1:0] | periph_event;
    end else begin
        pflag_nxt = pflag_r | periph_event;
    end
end

always @* begin
    if (pen_wr) begin
        pen_nxt = pwdata[PERIPH_N-1:0];
    end else begin
        pen_nxt = pen_r;
    end
end

always @* begin
    if (option_wr) begin
        option_nxt = pwdata[7:0];
    end else begin
        option_nxt = option_r;
    end
end

always @* begin
    // write one to clear, a new event in the same cycle stays set
    if (evt_stat_wr) begin
        evt_stat_nxt = (evt_stat_r & ~pwdata[2:0]) | ev_set;
    end else begin
        evt_stat_nxt = evt_stat_r | ev_set;
    end
end

always @* begin
    if (evt_mask_wr) begin
        evt_mask_nxt = pwdata[2:0];
    end else begin
        evt_mask_nxt = evt_mask_r;
    end
end

always @* begin
    if (insn_boundary) begin
        pend_nxt = intctl_r[`MIL_IC_GLOBAL_EN] & any_active;
    end else begin
        pend_nxt = pend_r;
    end
end

// ----------------------------------------
// interrupt registers
// ----------------------------------------
always @(posedge sys_clk) begin
    if (sys_rst) begin
        intctl_r <= `MIL_INTCTL_RST;
    end else begin
        intctl_r <= intctl_nxt;
    end
end

always @(posedge sys_clk) begin
    if (sys_rst) begin
        pflag_r <= `MIL_PERIPH_RST;
        pen_r <= `MIL_PERIPH_RST;
    end else begin
        pflag_r <= pflag_nxt;
        pen_r <= pen_nxt;
    end
end

always @(posedge sys_clk) begin
    if (sys_rst) begin
        option_r <= `MIL_OPTION_RST;
    end else begin
        option_r <= option_nxt;
    end
end

always @(posedge sys_clk) begin
    if (sys_rst) begin
        evt_stat_r <= 3'h0;
        evt_mask_r <= 3'h0;
    end else begin
        evt_stat_r <= evt_stat_nxt;
        evt_mask_r <= evt_mask_nxt;
    end
end

always @(posedge sys_clk) begin
    if (sys_rst) begin
        pend_r <= 1'b0;
    end else begin
        pend_r <= pend_nxt;
    end
end

// ----------------------------------------
// input samples
// ----------------------------------------
// samples track the pins through reset, so release shows no false edge
always @(posedge sys_clk) begin
    pin_q_r <= ext_irq_pin;
    port_q_r <= upper_nibble_port;
    timer0_q_r <= timer0_count;
end

// ----------------------------------------
// core side next values
// ----------------------------------------
reg pc_load_nxt;
reg [PC_W-1:0] pc_value_nxt;
reg stack_push_nxt;
reg [PC_W-1:0] stack_data_nxt;
reg wake_nxt;
reg irq_out_nxt;

always @* begin
    pc_load_nxt = take;
    stack_push_nxt = take;
    if (take) begin
        pc_value_nxt = `MIL_VECTOR_ADDR;
        stack_data_nxt = return_pc;
    end else begin
        pc_value_nxt = pc_value_r;
        stack_data_nxt = stack_data_r;
    end
end

always @* begin
    // wake ignores global enable; vectoring then follows it
    wake_nxt = sleep_active & any_active;
    irq_out_nxt = |((evt_stat_r | ev_set) & evt_mask_r);
end

// ----------------------------------------
// core side outputs
// ----------------------------------------
always @(posedge sys_clk) begin
    if (sys_rst) begin
        pc_load_r <= 1'b0;
        stack_push_r <= 1'b0;
    end else begin
        pc_load_r <= pc_load_nxt;
        stack_push_r <= stack_push_nxt;
    end
end

always @(posedge sys_clk) begin
    if (sys_rst) begin
        pc_value_r <= {PC_W{1'b0}};
        stack_data_r <= {PC_W{1'b0}};
    end else begin
        pc_value_r <= pc_value_nxt;
        stack_data_r <= stack_data_nxt;
    end
end

always @(posedge sys_clk) begin
    if (sys_rst) begin
        wake_r <= 1'b0;
        irq_out_r <= 1'b0;
    end else begin
        wake_r <= wake_nxt;
        irq_out_r <= irq_out_nxt;
    end
end

endmodule
`default_nettype wire

// ==== bench/mil_irq_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module mil_irq_chk #(
    parameter PC_W = 13
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire logic insn_boundary,
    input wire logic sleep_active,
    input wire logic [PC_W-1:0] return_pc,
    input wire logic pc_load_r,
    input wire logic [PC_W-1:0] pc_value_r,
    input wire logic stack_push_r,
    input wire logic [PC_W-1:0] stack_data_r,
    input wire logic wake_r
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable && !pready;
    endsequence
    apb_wait_a: assert property (setup_s ##1 access_s |=> pready)
        else $error("ready late");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    rdata_idle_a: assert property (!(pready && !pwrite) |-> prdata == 0)
        else $error("read data not idle");
    push_pair_a: assert property (stack_push_r == pc_load_r)
        else $error("push without load");
    vec_addr_a: assert property (pc_load_r |-> pc_value_r == 'h4)
        else $error("bad vector");
    take_cause_a: assert property (pc_load_r |->
        $past(insn_boundary) && !$past(sleep_active)) else $error("bad take");
    saved_pc_a: assert property (pc_load_r |->
        stack_data_r == $past(return_pc)) else $error("bad saved pc");
    wake_sleep_a: assert property ($rose(wake_r) |->
        $past(sleep_active))
        else $error("wake while awake");
    one_take_a: assert property (pc_load_r |=> !pc_load_r [*4])
        else $error("take repeated");
endmodule
bind mil_irq_logic mil_irq_chk #(.PC_W(PC_W)) chk(.*);
`default_nettype wire

// ==== bench/mil_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mil_core_model (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic pc_load_r,
    input wire logic [12:0] pc_value_r,
    output logic insn_boundary,
    output logic [12:0] return_pc
);
    // four clocks per instruction cycle, like a quarter-phase core
    logic [1:0] ph_r;
    logic [12:0] pc_r;
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            ph_r <= 2'h0;
            pc_r <= 13'h0;
        end else begin
            ph_r <= ph_r + 2'h1;
            if (pc_load_r) pc_r <= pc_value_r;
            else if (ph_r == 2'h3) pc_r <= pc_r + 13'h1;
        end
    end
    assign insn_boundary = (ph_r == 2'h3);
    // only the pc goes to the stack; working regs are software's job
    assign return_pc = pc_r;
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "mil_consts.vh"
module testbench;
    localparam [7:0] IC = `MIL_ADDR_INTCTL, OP = `MIL_ADDR_OPTION;
    logic sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic ext_irq_pin = 1, sleep_active = 0, return_from_irq_instr = 0;
    logic [7:0] paddr = 0, timer0_count = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [3:0] upper_nibble_port = 0;
    logic [5:0] periph_event = 0;
    logic pready, pslverr, insn_boundary, pc_load_r, stack_push_r;
    logic wake_r, irq_out_r, lerr;
    logic [12:0] return_pc, pc_value_r, stack_data_r;
    integer failures = 0, tests_run = 0, cyc = 0, n;
    mil_irq_logic uut(.*);
    mil_core_model core(.sys_clk(sys_clk), .sys_rst(sys_rst),
        .pc_load_r(pc_load_r), .pc_value_r(pc_value_r),
        .insn_boundary(insn_boundary), .return_pc(return_pc));
    always #12.5 sys_clk = ~sys_clk;
    task finish_test;
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // whole run is under two hundred cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            failures = failures + 1;
            finish_test;
        end
    end
    task tick(input integer k);
        repeat (k) @(posedge sys_clk);
    endtask
    task chk(input [31:0] g, input [31:0] e);
        tests_run = tests_run + 1;
        if (g !== e) begin
            failures = failures + 1;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task apb(input [7:0] a, input w, input [31:0] d, input [31:0] e);
        @(posedge sys_clk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1;
        @(posedge sys_clk);
        penable <= 1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        lerr = pslverr;
        if (!w) chk(prdata, e);
        psel <= 0;
        penable <= 0;
    endtask
    task pin(input v);
        ext_irq_pin <= v;
        tick(3);
    endtask
    task wait_for_take;
        n = 0;
        do begin
            @(posedge sys_clk);
            n = n + 1;
        end while (pc_load_r !== 1'b1 && wake_r !== 1'b1 && n < 40);
    endtask
    initial begin
        tick(2);
        sys_rst <= 0;
        apb(IC, 0, 0, 0);
        apb(OP, 0, 0, 32'hff);
        apb(`MIL_ADDR_VECTOR, 0, 0, 32'h4);
        apb(8'h1c, 0, 0, 0);
        chk(lerr, 1);
        apb(OP, 1, 0, 0);
        pin(0);
        apb(IC, 0, 0, 32'h2);
        apb(IC, 1, 0, 0);
        pin(1);
        apb(IC, 0, 0, 0);
        apb(OP, 1, 32'h40, 0);
        pin(0);
        apb(IC, 0, 0, 0);
        pin(1);
        apb(IC, 0, 0, 32'h2);
        apb(IC, 1, 0, 0);
        timer0_count <= 8'hff;
        tick(1);
        timer0_count <= 8'h00;
        upper_nibble_port <= 4'h8;
        tick(2);
        apb(IC, 0, 0, 32'h5);
        for (n = 0; n < 6; n = n + 1) begin
            periph_event <= 6'h1 << n;
            tick(1);
        end
        periph_event <= 0;
        apb(`MIL_ADDR_PFLAG, 0, 0, 32'h3f);
        apb(`MIL_ADDR_PFLAG, 1, 0, 0);
        pin(0);
        apb(IC, 1, 32'h90, 0);
        ext_irq_pin <= 1;
        wait_for_take;
        chk(pc_load_r, 1);
        chk(n <= 16, 1);
        apb(IC, 0, 0, 32'h12);
        apb(`MIL_ADDR_EVT_MASK, 1, 1, 0);
        tick(2);
        chk(irq_out_r, 1);
        apb(`MIL_ADDR_EVT_STAT, 1, 1, 0);
        tick(2);
        chk(irq_out_r, 0);
        apb(IC, 1, 32'h10, 0);
        return_from_irq_instr <= 1;
        tick(1);
        return_from_irq_instr <= 0;
        apb(IC, 0, 0, 32'h90);
        apb(IC, 1, 32'h10, 0);
        pin(0);
        sleep_active <= 1;
        ext_irq_pin <= 1;
        wait_for_take;
        chk(wake_r, 1);
        finish_test;
    end
endmodule
`default_nettype wire
